// ---- src/ipx_pkg.sv ----
// Package: constants and carrier types for the priority and external-pin block
package ipx_pkg;
  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  localparam logic [7:0] IPX_SFR_BASE = 8'h80;      // First special register address
  localparam logic [7:0] IPX_PRIO_ADDR = 8'hB8;     // Priority level register
  localparam logic [7:0] IPX_PINCFG_ADDR = 8'hE4;   // External pin configuration
  localparam logic [7:0] IPX_BIT_BASE_MASK = 8'hF8; // Bit address to owning byte
  localparam logic [6:0] IPX_PRIO_RESET = 7'h00;    // Priority bits after reset
  localparam logic [7:0] IPX_PINCFG_RESET = 8'h01;  // Pin configuration after reset
  localparam logic [7:0] IPX_READ_NONE = 8'h00;     // Data for unmapped reads
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IPX_PRIO_TOP = 7;      // Unused top bit, reads as one
  localparam int IPX_ONE_POL = 7;       // Input one polarity
  localparam int IPX_ONE_SEL_LO = 4;    // Input one pin select, bits 6..4
  localparam int IPX_ZERO_POL = 3;      // Input zero polarity
  localparam int IPX_ZERO_SEL_LO = 0;   // Input zero pin select, bits 2..0
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;      // Direct address, or bit address in bit mode
    logic read;            // Read strobe
    logic write;           // Write strobe
    logic bitMode;         // Single-bit access
    logic [7:0] wdata;     // Write byte; bit value in bit 0
  } ipx_req_t;
  typedef struct packed {
    logic serialPeriph;    // Priority of each source, 1 = high
    logic timerTwo;
    logic uartZero;
    logic timerOne;
    logic extOne;
    logic timerZero;
    logic extZero;
  } ipx_prio_t;
endpackage

// ---- src/ipx_core.sv ----
// Module: priority register, external pin configuration and pin monitors
`timescale 1ns/1ps
// Summary of operation
// - Addresses 0x80..0xFF reach the special registers
// - Bit access only on 0/8-ending registers
// - Priority bits six..zero, one means high
// - Pin monitoring independent of crossbar routing
module ipx_core
  import ipx_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire ipx_req_t sfrReq,
  input wire logic [7:0] port0Pins,
  output ipx_prio_t prioLevel,
  output logic [7:0] readData,
  output logic readValid,
  output logic [1:0] extIntActive
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // True when an access lands on the given register
  function automatic logic hits(input ipx_req_t r, input logic [7:0] target);
    logic [7:0] byteAddr;
    byteAddr = r.bitMode ? (r.addr & IPX_BIT_BASE_MASK) : r.addr;
    hits = (r.addr >= IPX_SFR_BASE) && (byteAddr == target);
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [6:0] prio_reg;        // Priority bits
  logic [6:0] prio_next;
  logic [7:0] cfg_reg;         // Pin configuration
  logic [7:0] cfg_next;
  logic [7:0] rdata_reg;       // Read answer
  logic [7:0] rdata_next;
  logic rvalid_reg;            // Read answer strobe
  logic rvalid_next;
  logic prioHit;
  logic cfgHit;
  logic [7:0] prioView;        // Priority as read, top bit one

  assign prioHit = hits(sfrReq, IPX_PRIO_ADDR);
  assign cfgHit = hits(sfrReq, IPX_PINCFG_ADDR);
  assign prioView = {1'b1, prio_reg};

  // Next values of registers and read answer
  always_comb begin
    prio_next = prio_reg;
    cfg_next = cfg_reg;
    rdata_next = IPX_READ_NONE;
    rvalid_next = sfrReq.read;
    if (sfrReq.write && prioHit) begin
      if (sfrReq.bitMode) begin
        if (sfrReq.addr[2:0] != 3'(IPX_PRIO_TOP)) begin
          prio_next[sfrReq.addr[2:0]] = sfrReq.wdata[0];
        end
      end else begin
        prio_next = sfrReq.wdata[6:0];
      end
    end
    // configuration is byte only; bit addresses never decode here
    if (sfrReq.write && cfgHit && !sfrReq.bitMode) begin
      cfg_next = sfrReq.wdata;
    end
    if (sfrReq.read && prioHit) begin
      // Bit reads return the bit in position zero
      if (sfrReq.bitMode) begin
        rdata_next = {7'h00, prioView[sfrReq.addr[2:0]]};
      end else begin
        rdata_next = prioView;
      end
    end else if (sfrReq.read && cfgHit && !sfrReq.bitMode) begin
      rdata_next = cfg_reg;
    end
  end

  // Register stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prio_reg <= IPX_PRIO_RESET;
      cfg_reg <= IPX_PINCFG_RESET;
      rdata_reg <= IPX_READ_NONE;
      rvalid_reg <= 1'b0;
    end else begin
      prio_reg <= prio_next;
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign prioLevel = ipx_prio_t'(prio_reg);
  assign readData = rdata_reg;
  assign readValid = rvalid_reg;

  // ----------------------------------------------------------------
  // Pin monitors
  // ----------------------------------------------------------------
  logic [7:0] sync1_reg;       // First stage, feeds second only
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] pinLevel_reg;    // Accepted pin levels
  logic [7:0] pinLevel_next;
  logic [1:0] ext_reg;         // Active-high interrupt levels
  logic [1:0] ext_next;
  logic [2:0] selOf [2];       // Selected pin of each input
  logic polOf [2];             // Polarity of each input

  assign selOf[0] = cfg_reg[IPX_ZERO_SEL_LO +: 3];
  assign selOf[1] = cfg_reg[IPX_ONE_SEL_LO +: 3];
  assign polOf[0] = cfg_reg[IPX_ZERO_POL];
  assign polOf[1] = cfg_reg[IPX_ONE_POL];

  // Accept a pin change once two late stages agree
  always_comb begin
    pinLevel_next = pinLevel_reg;
    for (int i = 0; i < 8; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) begin
        pinLevel_next[i] = sync3_reg[i];
      end
    end
  end

  // Selection and polarity per input
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gExt
      // select pin n, polarity one = high
      // pins are only sampled, never driven
      assign ext_next[g] = polOf[g] ? pinLevel_reg[selOf[g]] : ~pinLevel_reg[selOf[g]];
    end
  endgenerate

  // Synchroniser and monitor registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
      pinLevel_reg <= 8'h00;
      ext_reg <= 2'h0;
    end else begin
      sync1_reg <= port0Pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pinLevel_reg <= pinLevel_next;
      ext_reg <= ext_next;
    end
  end

  assign extIntActive = ext_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  lowAddr_ignored_a: assert property (
    (sfrReq.write && sfrReq.addr < IPX_SFR_BASE) |=> $stable(prio_reg) && $stable(cfg_reg))
    else $error("low address write changed a register");

  prioByte_write_a: assert property (
    (sfrReq.write && !sfrReq.bitMode && sfrReq.addr == IPX_PRIO_ADDR)
    |=> prioLevel == ipx_prio_t'($past(sfrReq.wdata[6:0])))
    else $error("priority byte write not stored");

  prioBit_write_a: assert property (
    (sfrReq.write && sfrReq.bitMode && (sfrReq.addr & IPX_BIT_BASE_MASK) == IPX_PRIO_ADDR
     && sfrReq.addr[2:0] != 3'h7)
    |=> prio_reg[$past(sfrReq.addr[2:0])] == $past(sfrReq.wdata[0]))
    else $error("priority bit write not stored");

  cfgBit_blocked_a: assert property (
    (sfrReq.write && sfrReq.bitMode) |=> $stable(cfg_reg))
    else $error("bit write reached configuration");

  // Unused top bit of the priority byte is never stored
  prioTop_kept_a: assert property (
    (sfrReq.write && sfrReq.bitMode && (sfrReq.addr & IPX_BIT_BASE_MASK) == IPX_PRIO_ADDR
     && sfrReq.addr[2:0] == 3'(IPX_PRIO_TOP)) |=> $stable(prio_reg))
    else $error("unused priority bit write stored");

  // Whole-byte configuration write lands as written
  cfgByte_write_a: assert property (
    (sfrReq.write && !sfrReq.bitMode && sfrReq.addr == IPX_PINCFG_ADDR)
    |=> cfg_reg == $past(sfrReq.wdata))
    else $error("configuration byte write not stored");

  // Bit read of the priority byte answers in position zero
  prioBit_read_a: assert property (
    (sfrReq.read && sfrReq.bitMode && (sfrReq.addr & IPX_BIT_BASE_MASK) == IPX_PRIO_ADDR)
    |=> readValid && readData == {7'h00, $past(prioView[sfrReq.addr[2:0]])})
    else $error("priority bit read wrong");

  readBack_a: assert property (
    (sfrReq.read && !sfrReq.bitMode && sfrReq.addr == IPX_PRIO_ADDR)
    |=> readValid && readData == {1'b1, $past(prio_reg)})
    else $error("priority read back wrong");

  // Pins and configuration unchanged long enough to cross the chain
  sequence quietInputs;
    ($stable(port0Pins) && $stable(cfg_reg)) [*5];
  endsequence

  extZero_follow_a: assert property (
    quietInputs |-> extIntActive[0] ==
      (cfg_reg[IPX_ZERO_POL] ? port0Pins[cfg_reg[2:0]] : !port0Pins[cfg_reg[2:0]]))
    else $error("input zero does not follow its pin");

  extOne_follow_a: assert property (
    quietInputs |-> extIntActive[1] ==
      (cfg_reg[IPX_ONE_POL] ? port0Pins[cfg_reg[6:4]] : !port0Pins[cfg_reg[6:4]]))
    else $error("input one does not follow its pin");

  unmapped_zero_a: assert property (
    (sfrReq.read && !prioHit && !cfgHit) |=> readValid && readData == IPX_READ_NONE)
    else $error("unmapped read not zero");
endmodule // ipx_core

// ---- dv/ipx_cpu_model.sv ----
// Processor-side model that issues register reads and writes
`timescale 1ns/1ps
module ipx_cpu_model
  import ipx_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] readData,
  input wire logic readValid,
  output ipx_req_t sfrReq
);
  // ----------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------
  // Idle bus from time zero
  initial begin
    sfrReq = '0;
  end
  // no address check: calls may name an unoccupied address, as the bench does with 8'h38
  // bit access: bit address in addr, value in bit 0
  task automatic access(input logic wr, input logic bm, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clock);
    #1;
    sfrReq = '{addr: a, read: !wr, write: wr, bitMode: bm, wdata: d};
    @(posedge clock);
    #1;
    q = readData;
    v = readValid;
    sfrReq = '0;
  endtask
endmodule // ipx_cpu_model

// ---- dv/test_ipx_core.sv ----
// Self-checking bench for the priority and external-pin block
`timescale 1ns/1ps
module test_ipx_core;
  import ipx_pkg::*;
  logic clock, rst_b; // Clock and active-low reset
  ipx_req_t sfrReq; // Request from the processor model
  logic [7:0] port0Pins, readData, q; // Pins, answer, captured answer
  logic readValid, v; // Answer strobe and its capture
  ipx_prio_t prioLevel; // Priority outputs
  logic [1:0] extIntActive; // Monitored inputs
  int error_cnt, cmp_count; // Mismatches and comparisons
  ipx_core dut_u (.clock(clock), .rst_b(rst_b), .sfrReq(sfrReq), .port0Pins(port0Pins),
    .prioLevel(prioLevel), .readData(readData), .readValid(readValid),
    .extIntActive(extIntActive));
  ipx_cpu_model cpu_u (.clock(clock), .readData(readData), .readValid(readValid),
    .sfrReq(sfrReq));
  // ----------------------------------------------------------------
  // Clock, compare and closing
  // ----------------------------------------------------------------
  // 50 ns period
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write through the processor model
  task automatic wr(input logic bm, input logic [7:0] a, input logic [7:0] d);
    cpu_u.access(1'h1, bm, a, d, q, v);
  endtask
  // Read, expect a strobe and the given data
  task automatic rd(input logic bm, input logic [7:0] a, input logic [7:0] exp);
    cpu_u.access(1'h0, bm, a, 8'h00, q, v);
    chk({7'h00, v}, 8'h01);
    chk(q, exp);
  endtask
  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    port0Pins = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    #1 rst_b = 1'h1;
    chk({1'h0, prioLevel}, 8'h00);
    rd(1'h0, IPX_PRIO_ADDR, 8'h80);
    rd(1'h0, IPX_PINCFG_ADDR, IPX_PINCFG_RESET);
    $display("test reset done");
    // Byte write, then a write and read of low address 8'h38, which no register stores
    wr(1'h0, IPX_PRIO_ADDR, 8'h55);
    chk({1'h0, prioLevel}, 8'h55);
    wr(1'h0, 8'h38, 8'h2A);
    chk({1'h0, prioLevel}, 8'h55);
    rd(1'h0, 8'h38, 8'h00);
    rd(1'h0, IPX_PRIO_ADDR, 8'hD5);
    $display("test byte done");
    // Priority bits set one after another by bit access
    wr(1'h0, IPX_PRIO_ADDR, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(1'h1, IPX_PRIO_ADDR + 8'(i), 8'h01);
      chk({1'h0, prioLevel}, 8'((2 << i) - 1));
      rd(1'h1, IPX_PRIO_ADDR + 8'(i), 8'h01);
    end
    wr(1'h1, 8'hBF, 8'h00);
    rd(1'h0, IPX_PRIO_ADDR, 8'hFF);
    wr(1'h1, IPX_PRIO_ADDR + 8'h02, 8'h00);
    rd(1'h0, IPX_PRIO_ADDR, 8'hFB);
    // Bit address E4 belongs to byte E0, config untouched
    wr(1'h0, IPX_PINCFG_ADDR, 8'h5A);
    wr(1'h1, IPX_PINCFG_ADDR, 8'h01);
    rd(1'h0, IPX_PINCFG_ADDR, 8'h5A);
    chk({6'h00, extIntActive}, 8'h02);
    $display("test bit done");
    // Every pin select on each input; input one high polarity, input zero low polarity
    for (int n = 0; n < 8; n++) begin
      wr(1'h0, IPX_PINCFG_ADDR, {1'h1, 3'(n), 1'h0, 3'(7 - n)});
      port0Pins = 8'h01 << n;
      repeat (6) @(posedge clock);
      #1;
      chk({6'h00, extIntActive}, 8'h03);
      port0Pins = ~(8'h01 << n);
      repeat (6) @(posedge clock);
      #1;
      chk({6'h00, extIntActive}, 8'h00);
    end
    $display("test pins done");
    print_verdict();
  end
endmodule // test_ipx_core
